// *** rtl/dbq_irq_status_clear.sv ***
// doorbell group 3 and rx/tx queue condition status, clear and ack logic
//
// Overview of operation
// - doorbell group 3 status at 0x230, sixteen read-only bits, upper reserved
// - doorbell group 3 clear at 0x238, sixteen write-only bits
// - receive queue status at 0x240, its clear at 0x248, sixteen bits
// - transmit queue status at 0x250, its clear at 0x258, sixteen bits
// - status read-only, clear write-only, everything zero after reset
// - each queue status bit reflects exactly one of sixteen queues
// - receive status bit n belongs to receive queue n
// - transmit status bit n belongs to transmit queue n
// - clear bit n acts on status bit n of the paired register
// - receive bit clears only when host pointer equals port pointer
// - transmit interrupt drops only when host pointer equals port pointer
//
// Register access over Wishbone was decided locally.
`timescale 1ns/1ps
module dbq_irq_status_clear
    import dbq_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire dbq_wb_req_t wb_req_i,
    output dbq_wb_rsp_t wb_rsp_o,
    input wire logic [NQ-1:0] doorbell_event_i,
    input wire logic [NQ-1:0] rx_event_i,
    input wire logic [NQ-1:0] tx_event_i,
    input wire dbq_cp_wr_t rx_port_cp_i,
    input wire dbq_cp_wr_t tx_port_cp_i,
    output logic [NQ-1:0] doorbell_status_o,
    output logic [NQ-1:0] rx_irq_status_o,
    output logic [NQ-1:0] tx_irq_status_o
);
    function automatic logic [DAT_W-1:0] byte_mask(
        input logic [SEL_W-1:0] sel
    );
        logic [DAT_W-1:0] m;
        m = DATA_RST;
        for (int b = 0; b < SEL_W; b++) begin
            m[b*BYTE_W +: BYTE_W] = {BYTE_W{sel[b]}};
        end
        return m;
    endfunction

    function automatic logic cp_hit(
        input logic [ADR_W-1:0] adr,
        input logic [ADR_W-1:0] base
    );
        return (adr & CP_SPAN_MASK) == base;
    endfunction

    function automatic logic [NQ-1:0] onehot(input logic [QI_W-1:0] q);
        logic [NQ-1:0] v;
        v = STATUS_RST;
        v[q] = 1'b1;
        return v;
    endfunction

    // ---------------- bus slave
    logic ack_reg;
    logic [DAT_W-1:0] rdat_reg;
    logic req_act;
    logic take;
    logic wr;
    logic [ADR_W-1:0] adr;
    logic [DAT_W-1:0] wmask;
    logic [DAT_W-1:0] wval;
    logic [QI_W-1:0] cp_q;
    logic [DAT_W-1:0] rd_value;

    assign req_act = wb_req_i.cyc & wb_req_i.stb;
    assign take = req_act & ack_reg;
    assign wr = take & wb_req_i.we;
    assign adr = wb_req_i.adr;
    assign wmask = byte_mask(wb_req_i.sel);
    assign wval = wb_req_i.dat & wmask;
    assign cp_q = adr[QI_LSB +: QI_W];

    // ack one cycle after the request; dropped right after so a request held
    // one cycle past its ack is not taken a second time
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_reg <= 1'b0;
        end else begin
            ack_reg <= req_act & ~ack_reg;
        end
    end

    // ---------------- completion pointers
    logic [CP_W-1:0] rx_sw_cp_reg [NQ];
    logic [CP_W-1:0] tx_sw_cp_reg [NQ];
    logic [CP_W-1:0] rx_port_cp_reg [NQ];
    logic [CP_W-1:0] tx_port_cp_reg [NQ];
    logic rx_cp_wr;
    logic tx_cp_wr;
    logic [CP_W-1:0] rx_cp_new;
    logic [CP_W-1:0] tx_cp_new;
    logic [NQ-1:0] rx_match;
    logic [NQ-1:0] tx_match;
    logic [NQ-1:0] rx_cp_eq;
    logic [NQ-1:0] tx_cp_eq;

    assign rx_cp_wr = wr & cp_hit(adr, RX_CP_BASE);
    assign tx_cp_wr = wr & cp_hit(adr, TX_CP_BASE);
    assign rx_cp_new = (rx_sw_cp_reg[cp_q] & ~wmask) | wval;
    assign tx_cp_new = (tx_sw_cp_reg[cp_q] & ~wmask) | wval;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            for (int q = 0; q < NQ; q++) begin
                rx_sw_cp_reg[q] <= CP_RST;
                tx_sw_cp_reg[q] <= CP_RST;
            end
        end else begin
            if (rx_cp_wr) begin
                rx_sw_cp_reg[cp_q] <= rx_cp_new;
            end
            if (tx_cp_wr) begin
                tx_sw_cp_reg[cp_q] <= tx_cp_new;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            for (int q = 0; q < NQ; q++) begin
                rx_port_cp_reg[q] <= CP_RST;
                tx_port_cp_reg[q] <= CP_RST;
            end
        end else begin
            if (rx_port_cp_i.we) begin
                rx_port_cp_reg[rx_port_cp_i.queue] <= rx_port_cp_i.value;
            end
            if (tx_port_cp_i.we) begin
                tx_port_cp_reg[tx_port_cp_i.queue] <= tx_port_cp_i.value;
            end
        end
    end

    // a pointer write that lands on the port value acks at once; an
    // explicit clear is honoured only while the pointers agree
    always_comb begin
        rx_match = STATUS_RST;
        tx_match = STATUS_RST;
        for (int q = 0; q < NQ; q++) begin
            rx_match[q] = rx_sw_cp_reg[q] == rx_port_cp_reg[q];
            tx_match[q] = tx_sw_cp_reg[q] == tx_port_cp_reg[q];
        end
    end

    assign rx_cp_eq = (rx_cp_wr && rx_cp_new == rx_port_cp_reg[cp_q]) ?
        onehot(cp_q) : STATUS_RST;
    assign tx_cp_eq = (tx_cp_wr && tx_cp_new == tx_port_cp_reg[cp_q]) ?
        onehot(cp_q) : STATUS_RST;

    // ---------------- clear strobes and status banks
    logic [NQ-1:0] db_clr_w;
    logic [NQ-1:0] rx_condition_clear_register_w;
    logic [NQ-1:0] tx_condition_clear_register_w;
    logic [NQ-1:0] rx_clr_w;
    logic [NQ-1:0] tx_clr_w;

    // only ones clear; clear registers hold nothing
    assign db_clr_w = (wr && adr == DB3_CLEAR_OFS) ?
        wval[NQ-1:0] : STATUS_RST;
    assign rx_condition_clear_register_w = (wr && adr == RX_CLEAR_OFS) ?
        wval[NQ-1:0] : STATUS_RST;
    assign tx_condition_clear_register_w = (wr && adr == TX_CLEAR_OFS) ?
        wval[NQ-1:0] : STATUS_RST;
    assign rx_clr_w = (rx_condition_clear_register_w & rx_match) | rx_cp_eq;
    assign tx_clr_w = (tx_condition_clear_register_w & tx_match) | tx_cp_eq;

    dbq_status_bank u_db3 (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .set_i(doorbell_event_i),
        .clr_i(db_clr_w),
        .status_o(doorbell_status_o)
    );

    // event n of queue n lands in bit n only
    dbq_status_bank u_rx (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .set_i(rx_event_i),
        .clr_i(rx_clr_w),
        .status_o(rx_irq_status_o)
    );

    dbq_status_bank u_tx (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .set_i(tx_event_i),
        .clr_i(tx_clr_w),
        .status_o(tx_irq_status_o)
    );

    // ---------------- read path
    always_comb begin
        rd_value = DATA_RST;
        if (cp_hit(adr, RX_CP_BASE)) begin
            rd_value = rx_port_cp_reg[cp_q];
        end else if (cp_hit(adr, TX_CP_BASE)) begin
            rd_value = tx_port_cp_reg[cp_q];
        end else begin
            unique case (adr)
                DB3_STATUS_OFS: begin
                    rd_value = {RSVD_ZERO, doorbell_status_o};
                end
                RX_STATUS_OFS: begin
                    rd_value = {RSVD_ZERO, rx_irq_status_o};
                end
                TX_STATUS_OFS: begin
                    rd_value = {RSVD_ZERO, tx_irq_status_o};
                end
                // clear registers and unmapped words read zero
                default: begin
                    rd_value = DATA_RST;
                end
            endcase
        end
    end

    // status writes are ignored: no path from bus data to status set
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rdat_reg <= DATA_RST;
        end else if (req_act & ~ack_reg) begin
            rdat_reg <= rd_value;
        end
    end

    assign wb_rsp_o.ack = ack_reg;
    assign wb_rsp_o.dat = rdat_reg;

    // ---------------- checks
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    logic past_rst;
    always_ff @(posedge clk_i) begin
        past_rst <= rst_i;
    end

    reset_zero_a: assert property (disable iff (1'b0)
        past_rst |-> (doorbell_status_o == STATUS_RST &&
        rx_irq_status_o == STATUS_RST && tx_irq_status_o == STATUS_RST &&
        !wb_rsp_o.ack))
        else $error("outputs not cleared by reset");

    ack_single_a: assert property (
        wb_rsp_o.ack |=> !wb_rsp_o.ack)
        else $error("ack held longer than one cycle");

    ack_follow_a: assert property (
        (req_act && !ack_reg) |=> wb_rsp_o.ack)
        else $error("request not answered in one cycle");

    db_set_a: assert property (
        (doorbell_event_i != STATUS_RST) |=>
        ((doorbell_status_o & $past(doorbell_event_i)) ==
        $past(doorbell_event_i)))
        else $error("doorbell event lost");

    db_clear_a: assert property (
        (wr && adr == DB3_CLEAR_OFS) ##1 1'b1 |->
        (doorbell_status_o & $past(wval[NQ-1:0] & ~doorbell_event_i,
        1)) == STATUS_RST)
        else $error("doorbell clear did not take");

    rx_guard_a: assert property (
        ((rx_irq_status_o & ~rx_event_i & ~rx_clr_w) != STATUS_RST) |=>
        ((rx_irq_status_o & $past(rx_irq_status_o & ~rx_clr_w)) ==
        $past(rx_irq_status_o & ~rx_clr_w)))
        else $error("rx bit dropped without matching ack");

    rx_mismatch_a: assert property (
        (rx_condition_clear_register_w & ~rx_match & ~rx_cp_eq & rx_irq_status_o) !=
        STATUS_RST |=> ((rx_irq_status_o & $past(rx_condition_clear_register_w & ~rx_match &
        ~rx_cp_eq & rx_irq_status_o)) != STATUS_RST))
        else $error("rx cleared while pointers differ");

    tx_ack_a: assert property (
        (tx_cp_eq & ~tx_event_i) != STATUS_RST |=>
        ((tx_irq_status_o & $past(tx_cp_eq & ~tx_event_i)) ==
        STATUS_RST))
        else $error("tx not released on equal pointer");

    tx_mismatch_a: assert property (
        (tx_condition_clear_register_w & ~tx_match & ~tx_cp_eq & tx_irq_status_o) !=
        STATUS_RST |=> ((tx_irq_status_o & $past(tx_condition_clear_register_w & ~tx_match &
        ~tx_cp_eq & tx_irq_status_o)) != STATUS_RST))
        else $error("tx cleared while pointers differ");

    clear_reads_a: assert property (
        (req_act && !ack_reg && !wb_req_i.we &&
        (adr == DB3_CLEAR_OFS || adr == RX_CLEAR_OFS ||
        adr == TX_CLEAR_OFS)) |=> wb_rsp_o.dat == DATA_RST)
        else $error("clear register read nonzero");

    rsvd_zero_a: assert property (
        (req_act && !ack_reg && adr == RX_STATUS_OFS) |=>
        (wb_rsp_o.dat[DAT_W-1:NQ] == RSVD_ZERO &&
        wb_rsp_o.dat[NQ-1:0] == $past(rx_irq_status_o)))
        else $error("rx status read wrong");

    set_wins_a: assert property (
        ((rx_event_i & rx_clr_w) != STATUS_RST) |=>
        ((rx_irq_status_o & $past(rx_event_i & rx_clr_w)) ==
        $past(rx_event_i & rx_clr_w)))
        else $error("clear beat a same-cycle event");

    db_clear_c: cover property (
        doorbell_status_o != STATUS_RST ##1 db_clr_w != STATUS_RST);
    rx_ack_c: cover property (
        rx_irq_status_o != STATUS_RST ##1 rx_cp_eq != STATUS_RST);
    tx_ack_c: cover property (
        tx_irq_status_o != STATUS_RST ##1 (tx_condition_clear_register_w & tx_match) != 0);
    rx_refuse_c: cover property (
        (rx_condition_clear_register_w & ~rx_match & rx_irq_status_o) != STATUS_RST);
endmodule

// *** rtl/dbq_pkg.sv ***
// shared constants and carrier types for the doorbell/queue condition block
package dbq_pkg;
    localparam int ADR_W = 12;
    localparam int DAT_W = 32;
    localparam int SEL_W = 4;
    localparam int NQ = 16;
    localparam int QI_W = 4;
    localparam int CP_W = 32;
    localparam int QI_LSB = 2;
    localparam int BYTE_W = 8;

    localparam logic [ADR_W-1:0] DB3_STATUS_OFS = 12'h230;
    localparam logic [ADR_W-1:0] DB3_CLEAR_OFS = 12'h238;
    localparam logic [ADR_W-1:0] RX_STATUS_OFS = 12'h240;
    localparam logic [ADR_W-1:0] RX_CLEAR_OFS = 12'h248;
    localparam logic [ADR_W-1:0] TX_STATUS_OFS = 12'h250;
    localparam logic [ADR_W-1:0] TX_CLEAR_OFS = 12'h258;
    localparam logic [ADR_W-1:0] RX_CP_BASE = 12'h300;
    localparam logic [ADR_W-1:0] TX_CP_BASE = 12'h340;
    localparam logic [ADR_W-1:0] CP_SPAN_MASK = 12'hFC3;

    localparam logic [NQ-1:0] STATUS_RST = 16'h0000;
    localparam logic [DAT_W-1:0] DATA_RST = 32'h00000000;
    localparam logic [CP_W-1:0] CP_RST = 32'h00000000;
    localparam logic [DAT_W-NQ-1:0] RSVD_ZERO = 16'h0000;

    typedef struct packed {
        logic cyc;
        logic stb;
        logic we;
        logic [ADR_W-1:0] adr;
        logic [SEL_W-1:0] sel;
        logic [DAT_W-1:0] dat;
    } dbq_wb_req_t;

    typedef struct packed {
        logic ack;
        logic [DAT_W-1:0] dat;
    } dbq_wb_rsp_t;

    typedef struct packed {
        logic we;
        logic [QI_W-1:0] queue;
        logic [CP_W-1:0] value;
    } dbq_cp_wr_t;
endpackage

// *** rtl/dbq_status_bank.sv ***
// sixteen sticky condition bits with set-over-clear priority
`timescale 1ns/1ps
module dbq_status_bank
    import dbq_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [NQ-1:0] set_i,
    input wire logic [NQ-1:0] clr_i,
    output logic [NQ-1:0] status_o
);
    logic [NQ-1:0] status_reg;
    logic [NQ-1:0] status_next;

    // a set landing with its clear is kept so no event is lost
    assign status_next = set_i | (status_reg & ~clr_i);

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            status_reg <= STATUS_RST;
        end else begin
            status_reg <= status_next;
        end
    end

    assign status_o = status_reg;
endmodule

// *** tb/tb_top.sv ***
// self-checking bench for the doorbell and queue condition registers
`timescale 1ns/1ps
module tb_top;
    import dbq_pkg::*;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    dbq_wb_req_t wb_req = '0;
    dbq_wb_rsp_t wb_rsp;
    logic [NQ-1:0] doorbell_event = '0;
    logic [NQ-1:0] rx_event = '0;
    logic [NQ-1:0] tx_event = '0;
    dbq_cp_wr_t rx_port_cp = '0;
    dbq_cp_wr_t tx_port_cp = '0;
    logic [NQ-1:0] db_stat, rx_stat, tx_stat;
    int errors = 0;
    int n_tests = 0;
    logic [DAT_W-1:0] rd;
    logic [ADR_W-1:0] ofs [6];

    always #10 clk_i = ~clk_i;

    dbq_irq_status_clear dut (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .wb_req_i(wb_req),
        .wb_rsp_o(wb_rsp),
        .doorbell_event_i(doorbell_event),
        .rx_event_i(rx_event),
        .tx_event_i(tx_event),
        .rx_port_cp_i(rx_port_cp),
        .tx_port_cp_i(tx_port_cp),
        .doorbell_status_o(db_stat),
        .rx_irq_status_o(rx_stat),
        .tx_irq_status_o(tx_stat)
    );

    task automatic finish_test();
        $display("comparisons %0d, mismatches %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic check(input string name, input logic [31:0] seen,
                         input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            errors++;
            $display("unexpected %s: expected %h, seen %h", name, exp, seen);
        end
    endtask

    // one classic cycle; request held until the edge where ack is seen
    task automatic wb_xfer(input logic we, input logic [ADR_W-1:0] adr,
                           input logic [DAT_W-1:0] dat,
                           output logic [DAT_W-1:0] rdat);
        int n;
        @(posedge clk_i);
        wb_req.cyc <= 1'b1;
        wb_req.stb <= 1'b1;
        wb_req.we <= we;
        wb_req.adr <= adr;
        wb_req.sel <= 4'hF;
        wb_req.dat <= dat;
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_rsp.ack !== 1'b1 && n < 50);
        if (n >= 50) begin
            check("ack wait", 32'h0, 32'h1);
        end
        rdat = wb_rsp.dat;
        wb_req.cyc <= 1'b0;
        wb_req.stb <= 1'b0;
        wb_req.we <= 1'b0;
    endtask

    task automatic wr(input logic [ADR_W-1:0] adr, input logic [31:0] dat);
        logic [DAT_W-1:0] dummy;
        wb_xfer(1'b1, adr, dat, dummy);
    endtask

    task automatic rd_chk(input string name, input logic [ADR_W-1:0] adr,
                          input logic [31:0] exp);
        logic [DAT_W-1:0] v;
        wb_xfer(1'b0, adr, '0, v);
        check(name, v, exp);
    endtask

    // one-cycle event pulse; the bit is set at the second edge
    task automatic pulse(input int k, input logic [NQ-1:0] v);
        @(posedge clk_i);
        if (k == 0) rx_event <= v;
        else if (k == 1) tx_event <= v;
        else doorbell_event <= v;
        @(posedge clk_i);
        rx_event <= '0;
        tx_event <= '0;
        doorbell_event <= '0;
    endtask

    task automatic port_cp(input int k, input logic [QI_W-1:0] q,
                           input logic [CP_W-1:0] v);
        @(posedge clk_i);
        if (k == 0) rx_port_cp <= '{we: 1'b1, queue: q, value: v};
        else tx_port_cp <= '{we: 1'b1, queue: q, value: v};
        @(posedge clk_i);
        rx_port_cp.we <= 1'b0;
        tx_port_cp.we <= 1'b0;
    endtask

    initial begin
        // a full run needs well under a thousand cycles
        repeat (5000) @(posedge clk_i);
        errors++;
        $display("unexpected watchdog: expected done, seen hang");
        finish_test();
    end

    initial begin
        logic [ADR_W-1:0] st, cl, cp;
        ofs = '{DB3_STATUS_OFS, DB3_CLEAR_OFS, RX_STATUS_OFS,
                RX_CLEAR_OFS, TX_STATUS_OFS, TX_CLEAR_OFS};
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        // all six status and clear registers read zero after reset, clear registers included
        foreach (ofs[i]) rd_chk("reset value", ofs[i], 32'h0);
        check("status outputs", {db_stat, rx_stat, tx_stat}, '0);

        // doorbell: set, write-one clears, write-zero keeps, status is RO
        pulse(2, 16'h8101);
        rd_chk("db status", DB3_STATUS_OFS, 32'h0000_8101);
        wr(DB3_STATUS_OFS, 32'hFFFF_FFFF);
        rd_chk("db status ro", DB3_STATUS_OFS, 32'h0000_8101);
        wr(DB3_CLEAR_OFS, 32'hFFFF_0001);
        rd_chk("db after clear", DB3_STATUS_OFS, 32'h0000_8100);
        rd_chk("db clear reads", DB3_CLEAR_OFS, 32'h0);
        check("db output", db_stat, 16'h8100);

        // rx then tx: bit n per queue n, clear gated by pointer equality
        for (int k = 0; k < 2; k++) begin
            st = k ? TX_STATUS_OFS : RX_STATUS_OFS;
            cl = k ? TX_CLEAR_OFS : RX_CLEAR_OFS;
            cp = (k ? TX_CP_BASE : RX_CP_BASE) + 12'h020;
            pulse(k, 16'h8101);
            rd_chk("q status", st, 32'h0000_8101);
            check("q output", k ? tx_stat : rx_stat, 16'h8101);
            check("other q output", k ? rx_stat : tx_stat, 16'h0);
            port_cp(k, 4'h8, 32'h0000_1234);
            wr(cl, 32'h0000_8101);
            rd_chk("q partial clear", st, 32'h0000_0100);
            wr(cp, 32'h0000_1111);
            rd_chk("q cp mismatch", st, 32'h0000_0100);
            rd_chk("q cp readback", cp, 32'h0000_1234);
            wr(cp, 32'h0000_1234);
            rd_chk("q cp match", st, 32'h0);
            rd_chk("q clear reads", cl, 32'h0);
        end

        // unmapped place answers, reads zero and ignores writes
        wr(12'h100, 32'hFFFF_FFFF);
        rd_chk("unmapped", 12'h100, 32'h0);
        check("final outputs", {db_stat, rx_stat, tx_stat}, 48'h8100_0000_0000);
        finish_test();
    end
endmodule
